// file: omc_pkg.sv
// Purpose: constants for the operating mode control block
// Assumes: APB slave with 32-bit data, one register word per offset
// Notes: mode register byte lives in the low eight bits of its word
package omc_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] OMC_MODE_OFFS = 12'h00B;
  localparam logic [11:0] OMC_MODE_ADDR = 12'h02C;
  localparam logic [11:0] OMC_DBG_OFFS = 12'h010;
  localparam logic [11:0] OMC_STAT_OFFS = 12'h014;
  // ************************************************************
  // mode register fields
  // ************************************************************
  localparam int OMC_B_SPECIAL_MODE_LOW_FLAG = 7;
  localparam int OMC_B_MODE_SELECT_HI = 6;
  localparam int OMC_B_MODE_SELECT_LO = 5;
  localparam int OMC_B_E_CLOCK_STRETCH_ENABLE = 4;
  localparam int OMC_B_INTERNAL_VISIBILITY = 3;
  localparam int OMC_B_EBSW = 2;
  localparam int OMC_B_ZERO = 1;
  localparam int OMC_B_EME = 0;
  // ************************************************************
  // debug control and status fields
  // ************************************************************
  localparam int OMC_B_DBG_EN = 0;
  localparam int OMC_B_DBG_REQ = 1;
  localparam int OMC_B_DBG_EXIT = 2;
  localparam int OMC_B_DBG_ACT = 3;
  // ************************************************************
  // memory map windows while debug is active
  // ************************************************************
  localparam logic [15:0] OMC_DBG_REG_LO = 16'hFF00;
  localparam logic [15:0] OMC_DBG_REG_HI = 16'hFF06;
  localparam logic [15:0] OMC_DBG_ROM_LO = 16'hFF20;
  localparam logic [15:0] OMC_DBG_ROM_HI = 16'hFFFF;
  // ************************************************************
  // mode encodings {special_n, mode_b, mode_a}
  // ************************************************************
  localparam logic [2:0] OMC_M_SSC = 3'h0;
  localparam logic [2:0] OMC_M_SEN = 3'h1;
  localparam logic [2:0] OMC_M_SPER = 3'h2;
  localparam logic [2:0] OMC_M_SEW = 3'h3;
  localparam logic [2:0] OMC_M_NSC = 3'h4;
  localparam logic [2:0] OMC_M_NEN = 3'h5;
  localparam logic [2:0] OMC_M_NRES = 3'h6;
  localparam logic [2:0] OMC_M_NEW = 3'h7;
  localparam logic [7:0] OMC_MODE_RST = 8'h10;
  localparam logic [31:0] OMC_RD_ZERO = 32'h00000000;
  // ************************************************************
  // startup sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    OMC_ST_RESET = 2'b01,
    OMC_ST_RUN = 2'b10
  } omc_state_t;
endpackage : omc_pkg

// file: omc_mode_ctrl.sv
// Purpose: operating mode selection, mode register and debug mapping
// Assumes: straps steady while reset is asserted, pins synchronous to pclk
// Notes: straps are caught on the first clock after presetn rises
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module omc_mode_ctrl
  import omc_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode strap pins
  input wire logic background_debug_pin,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  // debug activation sources
  input wire logic serial_debug_cmd,
  input wire logic enter_debug_instruction,
  // processor address for debug map decode
  input wire logic [15:0] cpu_addr,
  // mode outputs
  output logic cpu_halt,
  output logic ext_bus_en,
  output logic ext_bus_wide,
  output logic narrow_split,
  output logic port_ab_gpio,
  output logic port_ab_regs_mapped,
  output logic port_e_regs_mapped,
  output logic mode_reg_mapped,
  output logic e_clock_stretch_enable,
  output logic internal_visibility,
  output logic ext_bus_stop_in_wait,
  output logic background_debug_facility,
  output logic debug_active,
  output logic sel_debug_rom,
  output logic sel_debug_regs,
  output logic user_hi_mem_hidden
);
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic is_expanded(input logic [2:0] m);
    is_expanded = (m[0] == 1'b1);
  endfunction : is_expanded

  function automatic logic is_periph(input logic [2:0] m);
    is_periph = (m == OMC_M_SPER) || (m == OMC_M_NRES);
  endfunction : is_periph

  // ************************************************************
  // state
  // ************************************************************
  omc_state_t st_r, st_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic first_wr_r, first_wr_nxt;
  logic sel_once_r, sel_once_nxt;
  logic e_clock_stretch_enable_once_r, e_clock_stretch_enable_once_nxt;
  logic internal_visibility_once_r, internal_visibility_once_nxt;
  logic eme_once_r, eme_once_nxt;
  logic dbg_en_r, dbg_en_nxt;
  logic dbg_act_r, dbg_act_nxt;
  logic [2:0] mcode;
  logic special;
  logic wr_mode, wr_dbg, acc;
  logic [7:0] wb;
  logic [2:0] sel_new;

  assign mcode = mode_r[7:5];
  assign special = ~mode_r[OMC_B_SPECIAL_MODE_LOW_FLAG];
  assign acc = psel & penable;
  assign wb = pwdata[7:0];
  assign wr_mode = acc & pwrite & (paddr == OMC_MODE_ADDR) & ~is_periph(mcode);
  assign wr_dbg = acc & pwrite & (paddr == OMC_DBG_OFFS);
  assign sel_new = {mode_r[OMC_B_SPECIAL_MODE_LOW_FLAG], wb[OMC_B_MODE_SELECT_HI], wb[OMC_B_MODE_SELECT_LO]};

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    first_wr_nxt = first_wr_r;
    sel_once_nxt = sel_once_r;
    e_clock_stretch_enable_once_nxt = e_clock_stretch_enable_once_r;
    internal_visibility_once_nxt = internal_visibility_once_r;
    eme_once_nxt = eme_once_r;
    dbg_en_nxt = dbg_en_r;
    dbg_act_nxt = dbg_act_r;
    case (st_r)
      OMC_ST_RESET:
      begin
        mode_nxt[7:5] = {background_debug_pin, mode_select_hi, mode_select_lo};
        if ({background_debug_pin, mode_select_hi, mode_select_lo} == OMC_M_NRES)
        begin
          mode_nxt[7:5] = OMC_M_SPER;
        end
        mode_nxt[OMC_B_E_CLOCK_STRETCH_ENABLE] = 1'b1;
        mode_nxt[OMC_B_EBSW] = 1'b0;
        mode_nxt[OMC_B_ZERO] = 1'b0;
        mode_nxt[OMC_B_INTERNAL_VISIBILITY] = ~background_debug_pin;
        mode_nxt[OMC_B_EME] = ~background_debug_pin;
        dbg_en_nxt = ({background_debug_pin, mode_select_hi, mode_select_lo} == OMC_M_SSC);
        dbg_act_nxt = dbg_en_nxt;
        st_nxt = OMC_ST_RUN;
      end
      OMC_ST_RUN:
      begin
        if (wr_mode)
        begin
          first_wr_nxt = 1'b1;
          if (special)
          begin
            if (first_wr_r)
            begin
              mode_nxt[OMC_B_SPECIAL_MODE_LOW_FLAG] = wb[OMC_B_SPECIAL_MODE_LOW_FLAG];
              if (!is_periph({wb[OMC_B_SPECIAL_MODE_LOW_FLAG], wb[OMC_B_MODE_SELECT_HI], wb[OMC_B_MODE_SELECT_LO]}))
              begin
                mode_nxt[OMC_B_MODE_SELECT_HI] = wb[OMC_B_MODE_SELECT_HI];
                mode_nxt[OMC_B_MODE_SELECT_LO] = wb[OMC_B_MODE_SELECT_LO];
              end
              mode_nxt[OMC_B_INTERNAL_VISIBILITY] = wb[OMC_B_INTERNAL_VISIBILITY];
              mode_nxt[OMC_B_EME] = wb[OMC_B_EME];
            end
            mode_nxt[OMC_B_E_CLOCK_STRETCH_ENABLE] = wb[OMC_B_E_CLOCK_STRETCH_ENABLE];
          end
          else
          begin
            if (!sel_once_r && !is_periph(sel_new))
            begin
              mode_nxt[OMC_B_MODE_SELECT_HI] = wb[OMC_B_MODE_SELECT_HI];
              mode_nxt[OMC_B_MODE_SELECT_LO] = wb[OMC_B_MODE_SELECT_LO];
              sel_once_nxt = 1'b1;
            end
            if (!e_clock_stretch_enable_once_r)
            begin
              mode_nxt[OMC_B_E_CLOCK_STRETCH_ENABLE] = wb[OMC_B_E_CLOCK_STRETCH_ENABLE];
              e_clock_stretch_enable_once_nxt = 1'b1;
            end
            if (!internal_visibility_once_r)
            begin
              mode_nxt[OMC_B_INTERNAL_VISIBILITY] = wb[OMC_B_INTERNAL_VISIBILITY];
              internal_visibility_once_nxt = 1'b1;
            end
            if (!eme_once_r)
            begin
              mode_nxt[OMC_B_EME] = wb[OMC_B_EME];
              eme_once_nxt = 1'b1;
            end
            mode_nxt[OMC_B_EBSW] = wb[OMC_B_EBSW];
          end
          mode_nxt[OMC_B_ZERO] = 1'b0;
        end
        if (wr_dbg)
        begin
          dbg_en_nxt = pwdata[OMC_B_DBG_EN];
          if (pwdata[OMC_B_DBG_EXIT])
          begin
            dbg_act_nxt = 1'b0;
          end
        end
        if (dbg_en_r && (serial_debug_cmd || enter_debug_instruction ||
            (wr_dbg && pwdata[OMC_B_DBG_REQ])))
        begin
          dbg_act_nxt = 1'b1;
        end
        if (is_periph(mcode))
        begin
          dbg_act_nxt = 1'b0;
        end
      end
      default:
      begin
        st_nxt = OMC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= OMC_ST_RESET;
      mode_r <= OMC_MODE_RST;
      first_wr_r <= 1'b0;
      sel_once_r <= 1'b0;
      e_clock_stretch_enable_once_r <= 1'b0;
      internal_visibility_once_r <= 1'b0;
      eme_once_r <= 1'b0;
      dbg_en_r <= 1'b0;
      dbg_act_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      first_wr_r <= first_wr_nxt;
      sel_once_r <= sel_once_nxt;
      e_clock_stretch_enable_once_r <= e_clock_stretch_enable_once_nxt;
      internal_visibility_once_r <= internal_visibility_once_nxt;
      eme_once_r <= eme_once_nxt;
      dbg_en_r <= dbg_en_nxt;
      dbg_act_r <= dbg_act_nxt;
    end
  end

  // ************************************************************
  // apb read path
  // ************************************************************
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  always_comb
  begin
    rd_nxt = OMC_RD_ZERO;
    if (paddr == OMC_MODE_ADDR && !is_periph(mcode))
    begin
      rd_nxt[7:0] = mode_r;
      rd_nxt[OMC_B_ZERO] = 1'b0;
      rd_nxt[OMC_B_E_CLOCK_STRETCH_ENABLE] = mode_r[OMC_B_E_CLOCK_STRETCH_ENABLE] | is_expanded(mcode);
    end
    else if (paddr == OMC_DBG_OFFS)
    begin
      rd_nxt[OMC_B_DBG_EN] = dbg_en_r;
      rd_nxt[OMC_B_DBG_ACT] = dbg_act_r;
    end
    else if (paddr == OMC_STAT_OFFS)
    begin
      rd_nxt[2:0] = mcode;
      rd_nxt[4] = first_wr_r;
    end
  end

  // read word taken in the setup cycle, held through the access phase
  always_comb
  begin
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite)
    begin
      prdata_nxt = rd_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= OMC_RD_ZERO;
    end
    else
    begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc & ~((paddr == OMC_MODE_ADDR && !is_periph(mcode)) ||
                           paddr == OMC_DBG_OFFS ||
                           (paddr == OMC_STAT_OFFS && !pwrite));

  // ************************************************************
  // mode decode outputs
  // ************************************************************
  // processor held in peripheral
  assign cpu_halt = is_periph(mcode) | (st_r == OMC_ST_RESET);
  // single chip keeps ports general purpose
  assign ext_bus_en = is_expanded(mcode) | is_periph(mcode);
  assign port_ab_gpio = ~ext_bus_en;
  assign ext_bus_wide = (mcode[1:0] == 2'b11) | is_periph(mcode);
  assign narrow_split = (mcode[1:0] == 2'b01);
  assign port_ab_regs_mapped = ~ext_bus_en;
  assign port_e_regs_mapped = ~is_periph(mcode) &
                              ~(is_expanded(mcode) & mode_r[OMC_B_EME]);
  assign mode_reg_mapped = ~is_periph(mcode);
  assign e_clock_stretch_enable = mode_r[OMC_B_E_CLOCK_STRETCH_ENABLE] | is_expanded(mcode);
  assign internal_visibility = mode_r[OMC_B_INTERNAL_VISIBILITY] & ext_bus_en;
  assign ext_bus_stop_in_wait = mode_r[OMC_B_EBSW];
  assign background_debug_facility = dbg_en_r;
  assign debug_active = dbg_act_r;
  assign sel_debug_rom = dbg_act_r && cpu_addr >= OMC_DBG_ROM_LO;
  assign sel_debug_regs = dbg_act_r && cpu_addr >= OMC_DBG_REG_LO &&
                          cpu_addr <= OMC_DBG_REG_HI;
  assign user_hi_mem_hidden = dbg_act_r && cpu_addr >= OMC_DBG_REG_LO &&
                              cpu_addr <= OMC_DBG_ROM_HI;
endmodule : omc_mode_ctrl

// file: omc_mode_ctrl_asserts.sv
// Purpose: port checks for the operating mode control block
// Assumes: straps held steady across each reset
// Notes: attached to every omc_mode_ctrl by bind
`timescale 1ns/1ps
module omc_mode_ctrl_asserts
  import omc_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // straps and debug sources
  input wire logic background_debug_pin,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic serial_debug_cmd,
  input wire logic enter_debug_instruction,
  input wire logic [15:0] cpu_addr,
  // mode outputs
  input wire logic cpu_halt,
  input wire logic ext_bus_en,
  input wire logic ext_bus_wide,
  input wire logic narrow_split,
  input wire logic port_ab_gpio,
  input wire logic port_ab_regs_mapped,
  input wire logic mode_reg_mapped,
  input wire logic e_clock_stretch_enable,
  input wire logic background_debug_facility,
  input wire logic debug_active,
  input wire logic sel_debug_rom,
  input wire logic sel_debug_regs,
  input wire logic user_hi_mem_hidden
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_strap_decode:
    assert property ($rose(presetn) && mode_select_lo |-> ##2 ext_bus_en
      && ext_bus_wide == mode_select_hi && narrow_split != mode_select_hi) else $error("decode");
  a_periph_halt:
    assert property ($rose(presetn) && mode_select_hi && !mode_select_lo |-> ##2 cpu_halt[*4])
      else $error("no halt");
  a_gpio_nobus:
    assert property (port_ab_gpio |-> !ext_bus_en && port_ab_regs_mapped) else $error("gpio");
  a_wide_bus:
    assert property (!cpu_halt && ext_bus_wide |-> ext_bus_en && !narrow_split) else $error("wide");
  a_narrow_bus:
    assert property (narrow_split |-> ext_bus_en && !ext_bus_wide) else $error("narrow");
  a_ab_unmapped:
    assert property (ext_bus_en |-> !port_ab_regs_mapped) else $error("ports mapped");
  a_stretch_exp:
    assert property (ext_bus_en |-> e_clock_stretch_enable) else $error("stretch");
  a_mode_unmapped:
    assert property (psel && penable && paddr == OMC_MODE_ADDR && !mode_reg_mapped |-> pslverr)
      else $error("no error");
  a_bit1_zero:
    assert property (psel && penable && !pwrite && paddr == OMC_MODE_ADDR
      |-> !prdata[OMC_B_ZERO]) else $error("bit1 set");
  a_rom_select:
    assert property (sel_debug_rom == (debug_active && cpu_addr >= OMC_DBG_ROM_LO)
      && sel_debug_regs == (debug_active && cpu_addr inside {[OMC_DBG_REG_LO:OMC_DBG_REG_HI]}))
      else $error("debug map");
  a_hide_user:
    assert property (user_hi_mem_hidden == (debug_active && cpu_addr >= OMC_DBG_REG_LO))
      else $error("user map");
  a_ssc_debug:
    assert property ($rose(presetn) && !background_debug_pin && !mode_select_hi && !mode_select_lo
      |-> ##[1:3] debug_active && background_debug_facility) else $error("not active");
  a_debug_wake:
    assert property (background_debug_facility && !cpu_halt
      && (serial_debug_cmd || enter_debug_instruction) |-> ##[1:2] debug_active) else $error("wake");
endmodule : omc_mode_ctrl_asserts
bind omc_mode_ctrl omc_mode_ctrl_asserts omc_mode_ctrl_asserts_i (.*);

// file: omc_far_model.sv
// Purpose: strap pins and serial debug host beside the block
// Assumes: mode code changes only while reset is held
// Notes: serial command withheld in peripheral modes
`timescale 1ns/1ps
module omc_far_model (
  // choice from the bench
  input wire logic [2:0] mode_code,
  input wire logic cmd_req,
  // pins toward the block
  output logic background_debug_pin,
  output logic mode_select_hi,
  output logic mode_select_lo,
  output logic serial_debug_cmd
);
  assign {background_debug_pin, mode_select_hi, mode_select_lo} = mode_code;
  assign serial_debug_cmd = cmd_req && (mode_code[1:0] != 2'b10);
endmodule : omc_far_model

// file: tb_top.sv
// Purpose: register and mode tests for the operating mode control block
// Assumes: zero wait state apb slave
// Notes: each test starts from a strapped reset
`timescale 1ns/1ps
module tb_top
  import omc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] mode_code;
  logic cmd_req, enter_debug_instruction, serial_debug_cmd;
  logic background_debug_pin, mode_select_hi, mode_select_lo;
  logic [15:0] cpu_addr;
  logic cpu_halt, port_ab_gpio, ext_bus_wide, debug_active;
  logic sel_debug_rom, sel_debug_regs, user_hi_mem_hidden;
  logic port_e_regs_mapped, internal_visibility, ext_bus_stop_in_wait;
  int mismatches, check_count, cyc;
  logic [15:0] addr_tab [6] = '{16'hFEFF, 16'hFF00, 16'hFF06, 16'hFF07, 16'hFF20, 16'hFFFF};
  logic [2:0] sel_tab [6] = '{3'h0, 3'h3, 3'h3, 3'h1, 3'h5, 3'h5};
  omc_far_model omc_far_model_i (.mode_code, .cmd_req, .background_debug_pin,
    .mode_select_hi, .mode_select_lo, .serial_debug_cmd);
  omc_mode_ctrl omc_mode_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .background_debug_pin, .mode_select_hi, .mode_select_lo,
    .serial_debug_cmd, .enter_debug_instruction, .cpu_addr, .cpu_halt, .ext_bus_en(),
    .ext_bus_wide, .narrow_split(), .port_ab_gpio, .port_ab_regs_mapped(),
    .port_e_regs_mapped, .mode_reg_mapped(), .e_clock_stretch_enable(),
    .internal_visibility, .ext_bus_stop_in_wait, .background_debug_facility(),
    .debug_active, .sel_debug_rom, .sel_debug_regs, .user_hi_mem_hidden);
  // ************************************************************
  // tasks
  // ************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task do_reset(input logic [2:0] m);
    @(posedge pclk);
    presetn <= 1'b0;
    mode_code <= m;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : do_reset
  task wr_rd(input logic [7:0] d, input logic [7:0] exp);
    apb(OMC_MODE_ADDR, 1'b1, {24'h000000, d});
    apb(OMC_MODE_ADDR, 1'b0, 32'h00000000);
    chk(q, {24'h000000, exp});
  endtask : wr_rd
  task pulse(input logic ser);
    @(posedge pclk);
    if (ser) cmd_req <= 1'b1;
    else enter_debug_instruction <= 1'b1;
    @(posedge pclk);
    cmd_req <= 1'b0;
    enter_debug_instruction <= 1'b0;
  endtask : pulse
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // ************************************************************
  // clock, timeout and tests
  // ************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, cmd_req, enter_debug_instruction} = 6'h00;
    {paddr, pwdata, mode_code, cpu_addr} = '0;
    for (int i = 0; i < 8; i++)
    begin
      do_reset(i[2:0]);
      apb(OMC_MODE_ADDR, 1'b0, 32'h00000000);
      if (i[1:0] == 2'b10)
      begin
        chk(32'(e), 32'h1);
        chk(32'(cpu_halt), 32'h1);
        chk(32'(port_e_regs_mapped), 32'h0);
        apb(OMC_STAT_OFFS, 1'b0, 32'h00000000);
        chk(32'(q[2:0]), 32'(OMC_M_SPER));
      end
      else
      begin
        chk(q, {24'h0, i[2:0], 1'b1, ~i[2], 2'b00, ~i[2]});
        chk(32'(port_ab_gpio), 32'(i[1:0] == 2'b00));
        chk(32'(debug_active), 32'(i == 0));
        chk(32'(port_e_regs_mapped), 32'(!(i[0] && !i[2])));
        chk(32'(internal_visibility), 32'(i[0] && !i[2]));
      end
    end
    $display("test strap modes done");
    do_reset(OMC_M_SEN);
    wr_rd(8'h70, 8'h39);
    wr_rd(8'h70, 8'h70);
    chk(32'(port_e_regs_mapped), 32'h1);
    chk(32'(internal_visibility), 32'h0);
    wr_rd(8'h50, 8'h70);
    wr_rd(8'h36, 8'h30);
    chk(32'(ext_bus_stop_in_wait), 32'h0);
    $display("test special writes done");
    do_reset(OMC_M_NSC);
    wr_rd(8'hD0, 8'h90);
    wr_rd(8'hF6, 8'hF4);
    chk(32'(ext_bus_stop_in_wait), 32'h1);
    wr_rd(8'h20, 8'hF0);
    chk(32'(ext_bus_wide), 32'h1);
    apb(12'h100, 1'b0, 32'h00000000);
    chk(32'(e), 32'h1);
    $display("test normal writes done");
    do_reset(OMC_M_NSC);
    pulse(1'b0);
    apb(OMC_DBG_OFFS, 1'b0, 32'h00000000);
    chk(q, 32'h00000000);
    apb(OMC_DBG_OFFS, 1'b1, 32'h00000001);
    pulse(1'b0);
    apb(OMC_DBG_OFFS, 1'b0, 32'h00000000);
    chk(q, 32'h00000009);
    for (int i = 0; i < 6; i++)
    begin
      cpu_addr <= addr_tab[i];
      @(posedge pclk);
      chk(32'({sel_debug_rom, sel_debug_regs, user_hi_mem_hidden}), 32'(sel_tab[i]));
    end
    apb(OMC_DBG_OFFS, 1'b1, 32'h00000005);
    apb(OMC_DBG_OFFS, 1'b0, 32'h00000000);
    chk(q, 32'h00000001);
    pulse(1'b1);
    apb(OMC_DBG_OFFS, 1'b0, 32'h00000000);
    chk(q, 32'h00000009);
    $display("test debug done");
    end_of_test();
  end
endmodule : tb_top
